// *** rtl/cps_pkg.sv ***
// Constants for the program sequencer and core registers.
// Assumes a single core clock and a decoder that supplies operation codes.
package cps_pkg;
   // ******************************************************
   // Widths
   // ******************************************************
   localparam int PC_W       = 17;
   localparam int DADDR_W    = 16;
   // ******************************************************
   // Fixed program addresses
   // ******************************************************
   localparam logic [16:0] RESET_ADDR_LOW  = 17'h00000;
   localparam logic [16:0] RESET_ADDR_HIGH = 17'h0FE00;
   localparam logic [16:0] VEC_BASE        = 17'h00003;
   localparam logic [16:0] VEC_STEP        = 17'h00008;
   localparam logic [16:0] VEC_LAST        = 17'h0004B;
   localparam int          VEC_COUNT       = 10;
   localparam logic [16:0] OPT_AREA_BIG    = 17'h1FF00;
   localparam logic [16:0] OPT_AREA_SMALL  = 17'h0FF00;
   localparam logic [16:0] REL_JUMP_BIAS   = 17'h00002;
   localparam logic [16:0] ACC_CALL_BIAS   = 17'h00001;
   // ******************************************************
   // Data space map
   // ******************************************************
   localparam logic [15:0] ACC_ADDR        = 16'hFE00;
   localparam logic [15:0] OPH_ADDR        = 16'hFE01;
   localparam logic [15:0] CREG_ADDR       = 16'hFE02;
   localparam logic [15:0] SFR_BASE        = 16'hFE00;
   localparam logic [15:0] IND_REG_LAST    = 16'h007F;
   localparam logic [7:0]  REG_RESET       = 8'h00;
   localparam int          STATUS_NINTH_BIT = 1;
   // ******************************************************
   // Program-flow operations from the decoder
   // ******************************************************
   typedef enum logic [8:0] {
      CPS_OP_SEQ     = 9'h001,
      CPS_OP_JUMP    = 9'h002,
      CPS_OP_RJUMP   = 9'h004,
      CPS_OP_BRANCH  = 9'h008,
      CPS_OP_CALL    = 9'h010,
      CPS_OP_RELATIVE_CALL   = 9'h020,
      CPS_OP_ACALL   = 9'h040,
      CPS_OP_RET     = 9'h080,
      CPS_OP_HOLD    = 9'h100
   } cps_op_e;
   // ******************************************************
   // Push and pop sequence states
   // ******************************************************
   typedef enum logic [2:0] {
      CPS_ST_RUN   = 3'h1,
      CPS_ST_PUSH2 = 3'h2,
      CPS_ST_POP2  = 3'h4
   } cps_state_e;
endpackage

// *** rtl/cps_sequencer.sv ***
// Program counter sequencer with accumulator, B and C registers.
// Assumes the decoder gives one operation per cycle and stack RAM answers
// reads in the same cycle.
`timescale 1ns/100ps
module cps_sequencer
   import cps_pkg::*;
#(
   parameter bit BIG_ROM = 1'b1
) (
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               srst,
   input  wire logic               start_high_opt,
   // Decoder
   input  wire logic [8:0]         op,
   input  wire logic [2:0]         instr_len,
   input  wire logic               cond_taken,
   input  wire logic [7:0]         disp8,
   input  wire logic [11:0]        disp12,
   input  wire logic [16:0]        target17,
   // Interrupt acceptance
   input  wire logic               irq_accept,
   input  wire logic [3:0]         irq_group,
   // Register writes from the datapath
   input  wire logic               data_wr,
   input  wire logic [15:0]        data_addr,
   input  wire logic [7:0]         data_wdata,
   input  wire logic               muldiv_wr,
   input  wire logic [23:0]        muldiv_result,
   input  wire logic               ext_access,
   input  wire logic [15:0]        ext_low_addr,
   // Table look-up
   input  wire logic               table_lookup_read,
   input  wire logic [16:0]        table_addr,
   // Stack
   input  wire logic [15:0]        stack_ptr,
   input  wire logic [8:0]         stack_rdata,
   // Status word ninth bit
   input  wire logic               ram_ninth_bit_flag,
   // Outputs
   output logic [16:0]             pc,
   output logic                    bank_select_flag,
   output logic                    stack_wr,
   output logic [15:0]             stack_addr,
   output logic [8:0]              stack_wdata,
   output logic                    sp_step_up,
   output logic                    sp_step_down,
   output logic [17:0]             rom_addr,
   output logic                    opt_area_hit,
   output logic [23:0]             ext_addr,
   output logic [7:0]              data_rdata,
   output logic [7:0]              accumulator_reg,
   output logic [7:0]              operand_high_reg,
   output logic [7:0]              c_reg,
   output logic                    ind_reg_region,
   output logic                    sfr_region
);
   // ******************************************************
   // Next-address forming
   // ******************************************************
   cps_state_e  state;
   logic [8:0]  pend_high;
   logic [16:0] ret_pc;
   logic        ret_bank;
   wire  [16:0] len17      = {14'h0000, instr_len};
   wire  [16:0] seq_pc     = pc + len17;
   wire  [16:0] off12      = {{5{disp12[11]}}, disp12};
   wire  [16:0] off8       = {{9{disp8[7]}}, disp8};
   wire  [16:0] rel_pc     = pc + REL_JUMP_BIAS + off12;
   wire  [16:0] acc_pc     = pc + ACC_CALL_BIAS + {9'h000, accumulator_reg};
   wire  [16:0] br_pc      = pc + len17 + off8;
   wire  [16:0] vec_pc     = VEC_BASE + (17'(irq_group) << 3);
   wire         vec_ok     = irq_group < 4'(VEC_COUNT);
   wire  [16:0] start_pc   = start_high_opt ? RESET_ADDR_HIGH : RESET_ADDR_LOW;
   wire         is_call    = op == CPS_OP_CALL || op == CPS_OP_RELATIVE_CALL || op == CPS_OP_ACALL;
   wire         do_irq     = irq_accept && vec_ok && state == CPS_ST_RUN;
   wire         do_call    = is_call && state == CPS_ST_RUN && !do_irq;
   wire         do_ret     = op == CPS_OP_RET && state == CPS_ST_RUN && !do_irq;
   logic [16:0] next_pc;
   logic        next_bank;
   always_comb begin
      next_pc   = pc;
      next_bank = bank_select_flag;
      if (do_irq) begin
         next_pc   = vec_pc;
         next_bank = 1'b0;
      end else if (state == CPS_ST_POP2) begin
         next_pc   = {pend_high, stack_rdata[7:0]};
         next_bank = stack_rdata[8];
      end else if (state == CPS_ST_RUN) begin
         unique case (op)
            CPS_OP_SEQ:    next_pc = seq_pc;
            CPS_OP_JUMP,
            CPS_OP_CALL:   next_pc = target17;
            CPS_OP_RJUMP,
            CPS_OP_RELATIVE_CALL:  next_pc = rel_pc;
            CPS_OP_ACALL:  next_pc = acc_pc;
            CPS_OP_BRANCH: next_pc = cond_taken ? br_pc : seq_pc;
            default:       next_pc = pc;
         endcase
      end
   end
   // ******************************************************
   // Stack transfers
   // ******************************************************
   // Return address of a call is the next instruction
   wire  [16:0] push_pc    = do_irq ? pc : seq_pc;
   // Counter and bank flag; reset start follows the option pin
   always_ff @(posedge mclk) begin
      if (srst) begin
         pc               <= start_pc;
         bank_select_flag <= 1'b0;
      end else begin
         pc               <= next_pc;
         bank_select_flag <= next_bank;
      end
   end
   // Push and pop sequencing
   always_ff @(posedge mclk) begin
      if (srst) begin
         state            <= CPS_ST_RUN;
         pend_high        <= 9'h000;
         ret_pc           <= 17'h00000;
         ret_bank         <= 1'b0;
         stack_wr         <= 1'b0;
         stack_addr       <= 16'h0000;
         stack_wdata      <= 9'h000;
         sp_step_up       <= 1'b0;
         sp_step_down     <= 1'b0;
      end else begin
         stack_wr         <= 1'b0;
         sp_step_up       <= 1'b0;
         sp_step_down     <= 1'b0;
         unique case (state)
            CPS_ST_RUN: begin
               if (do_irq || do_call) begin
                  stack_wr    <= 1'b1;
                  stack_addr  <= stack_ptr + 16'h0001;
                  stack_wdata <= {bank_select_flag, push_pc[7:0]};
                  sp_step_up  <= 1'b1;
                  ret_pc      <= push_pc;
                  ret_bank    <= bank_select_flag;
                  state       <= CPS_ST_PUSH2;
               end else if (do_ret) begin
                  pend_high    <= stack_rdata;
                  stack_addr   <= stack_ptr - 16'h0001;
                  sp_step_down <= 1'b1;
                  state        <= CPS_ST_POP2;
               end
            end
            CPS_ST_PUSH2: begin
               stack_wr    <= 1'b1;
               stack_addr  <= stack_addr + 16'h0001;
               stack_wdata <= ret_pc[16:8];
               sp_step_up  <= 1'b1;
               state       <= CPS_ST_RUN;
            end
            CPS_ST_POP2: begin
               sp_step_down <= 1'b1;
               state        <= CPS_ST_RUN;
            end
         endcase
         if (srst == 1'b0 && state == CPS_ST_RUN && op == CPS_OP_HOLD && !do_irq) begin
            state <= CPS_ST_RUN;
         end
      end
   end
   // ******************************************************
   // Reset delayed one cycle; start option is read while reset is held
   // ******************************************************
   logic in_reset;
   always_ff @(posedge mclk) begin
      in_reset <= srst;
   end
   // ******************************************************
   // Program memory view
   // ******************************************************
   wire [16:0] opt_base = BIG_ROM ? OPT_AREA_BIG : OPT_AREA_SMALL;
   wire [16:0] fetch_a  = table_lookup_read ? table_addr : pc;
   always_ff @(posedge mclk) begin
      if (srst) begin
         rom_addr     <= 18'h00000;
         opt_area_hit <= 1'b0;
      end else begin
         rom_addr     <= {bank_select_flag, fetch_a};
         opt_area_hit <= !bank_select_flag && fetch_a[16:8] == opt_base[16:8]
                         && !table_lookup_read;
      end
   end
   // ******************************************************
   // Core registers
   // ******************************************************
   wire wr_acc = data_wr && data_addr == ACC_ADDR;
   wire wr_oph = data_wr && data_addr == OPH_ADDR;
   wire wr_c   = data_wr && data_addr == CREG_ADDR;
   wire [7:0] rd_mux = data_addr == ACC_ADDR  ? accumulator_reg :
                       data_addr == OPH_ADDR  ? operand_high_reg :
                       data_addr == CREG_ADDR ? c_reg : 8'h00;
   // Multiply/divide result wins over a plain write in the same cycle
   always_ff @(posedge mclk) begin
      if (srst) begin
         accumulator_reg <= REG_RESET;
      end else if (muldiv_wr) begin
         accumulator_reg <= muldiv_result[7:0];
      end else if (wr_acc) begin
         accumulator_reg <= data_wdata;
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         operand_high_reg <= REG_RESET;
      end else if (muldiv_wr) begin
         operand_high_reg <= muldiv_result[15:8];
      end else if (wr_oph) begin
         operand_high_reg <= data_wdata;
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         c_reg <= REG_RESET;
      end else if (muldiv_wr) begin
         c_reg <= muldiv_result[23:16];
      end else if (wr_c) begin
         c_reg <= data_wdata;
      end
   end
   // ******************************************************
   // Data reads, external address and region flags
   // ******************************************************
   // Read data lags the address by one cycle
   always_ff @(posedge mclk) begin
      if (srst) begin
         data_rdata <= 8'h00;
      end else begin
         data_rdata <= rd_mux;
      end
   end
   // High byte is taken as it stands when the access starts
   always_ff @(posedge mclk) begin
      if (srst) begin
         ext_addr <= 24'h000000;
      end else if (ext_access) begin
         ext_addr <= {operand_high_reg, ext_low_addr};
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         ind_reg_region <= 1'b0;
         sfr_region     <= 1'b0;
      end else begin
         ind_reg_region <= data_addr <= IND_REG_LAST;
         sfr_region     <= data_addr >= SFR_BASE;
      end
   end
   // Ninth bit is carried by the status word, not stored here
   wire unused_ok = ram_ninth_bit_flag ^ in_reset ^ ret_bank;
endmodule // cps_sequencer

// *** sim/cps_sequencer_chk.sv ***
// Concurrent checks on the program sequencer ports.
// Assumes it is bound into cps_sequencer and sees only that module's ports.
`timescale 1ns/100ps
module cps_seq_chk
   import cps_pkg::*;
(
   // Clock, reset and inputs
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic        start_high_opt,
   input wire logic [8:0]  op,
   input wire logic [2:0]  instr_len,
   input wire logic [11:0] disp12,
   input wire logic [16:0] target17,
   input wire logic        irq_accept,
   input wire logic [3:0]  irq_group,
   input wire logic [15:0] stack_ptr,
   input wire logic [8:0]  stack_rdata,
   // Outputs
   input wire logic [16:0] pc,
   input wire logic        bank_select_flag,
   input wire logic        stack_wr,
   input wire logic [15:0] stack_addr,
   input wire logic [8:0]  stack_wdata,
   input wire logic [7:0]  accumulator_reg,
   input wire logic [7:0]  operand_high_reg,
   input wire logic [7:0]  c_reg
);
   // Second cycle of a push or pop ignores the decoder, so track it here
   logic busy;
   wire  go = !busy && !irq_accept;
   always_ff @(posedge mclk) begin
      busy <= !srst && !busy && (irq_accept || op inside {CPS_OP_CALL, CPS_OP_RELATIVE_CALL,
         CPS_OP_ACALL, CPS_OP_RET});
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // ******************************************************
   // Properties
   // ******************************************************
   property p_rst; $fell(srst) |-> pc == ($past(start_high_opt) ? RESET_ADDR_HIGH
      : RESET_ADDR_LOW) && !bank_select_flag
      && {accumulator_reg, operand_high_reg, c_reg} == 24'h000000; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_seq; go && op == CPS_OP_SEQ |=> pc == 17'($past(pc) + $past(instr_len))
      && $stable(bank_select_flag); endproperty
   a_seq: assert property (p_seq) else $error("sequential step wrong");
   property p_jump; go && op == CPS_OP_JUMP |=> pc == $past(target17); endproperty
   a_jump: assert property (p_jump) else $error("jump target wrong");
   property p_rjump; go && op == CPS_OP_RJUMP |=> pc == 17'($past(pc) + 17'h00002
      + {{5{$past(disp12[11])}}, $past(disp12)}); endproperty
   a_rjump: assert property (p_rjump) else $error("relative jump wrong");
   property p_irq; !busy && irq_accept |=> pc == 17'(3 + 8 * $past(irq_group))
      && !bank_select_flag; endproperty
   a_irq: assert property (p_irq) else $error("vector wrong");
   property p_push; go && op == CPS_OP_CALL |=> stack_wr && stack_addr == 16'($past(stack_ptr) + 1)
      && stack_wdata[8] == $past(bank_select_flag)
      ##1 stack_wr && stack_addr == 16'($past(stack_ptr, 2) + 2); endproperty
   a_push: assert property (p_push) else $error("push order wrong");
   property p_pop; go && op == CPS_OP_RET |-> ##2 pc == {$past(stack_rdata, 2),
      $past(stack_rdata[7:0])} && bank_select_flag == $past(stack_rdata[8]); endproperty
   a_pop: assert property (p_pop) else $error("return address wrong");
   property p_bank; $rose(bank_select_flag) |-> $past(op, 2) == CPS_OP_RET; endproperty
   a_bank: assert property (p_bank) else $error("bank set outside return");
endmodule // cps_seq_chk

bind cps_sequencer cps_seq_chk u_cps_seq_chk (.*);

// *** sim/tb_top.sv ***
// Self-checking bench for the program sequencer.
// Assumes stack RAM data is supplied by the bench in the cycles the pop needs.
`timescale 1ns/100ps
module tb_top
   import cps_pkg::*;
;
   logic        mclk = 1'b0, srst = 1'b1, start_high_opt = 1'b0, cond_taken = 1'b0;
   logic        irq_accept = 1'b0, data_wr = 1'b0, muldiv_wr = 1'b0, ext_access = 1'b0;
   logic        table_lookup_read = 1'b0, ram_ninth_bit_flag = 1'b0;
   logic [8:0]  op = CPS_OP_HOLD, stack_rdata = 9'h000;
   logic [2:0]  instr_len = 3'h1;
   logic [7:0]  disp8 = 8'h00, data_wdata = 8'h00;
   logic [11:0] disp12 = 12'h000;
   logic [16:0] target17 = 17'h00000, table_addr = 17'h00000;
   logic [3:0]  irq_group = 4'h0;
   logic [15:0] data_addr = 16'h0000, ext_low_addr = 16'h0000, stack_ptr = 16'h0100;
   logic [23:0] muldiv_result = 24'h000000, ext_addr;
   logic [16:0] pc;
   logic        bank_select_flag, stack_wr, sp_step_up, sp_step_down, opt_area_hit;
   logic        ind_reg_region, sfr_region;
   logic [15:0] stack_addr;
   logic [8:0]  stack_wdata;
   logic [17:0] rom_addr;
   logic [7:0]  data_rdata, accumulator_reg, operand_high_reg, c_reg;
   int          n_mismatch = 0, total_checks = 0;
   cps_sequencer #(.BIG_ROM(1'b1)) u_cps_sequencer (.*);
   // ******************************************************
   // Tasks
   // ******************************************************
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Op is held only one cycle so a stale op never runs twice
   task automatic issue(input logic [8:0] o, input logic [2:0] n, input logic [16:0] t,
                        input logic [11:0] d, input logic c);
      @(posedge mclk);
      op <= o;
      instr_len <= n;
      target17 <= t;
      disp12 <= d;
      disp8 <= d[7:0];
      cond_taken <= c;
      @(posedge mclk);
      op <= CPS_OP_HOLD;
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      data_wr <= 1'b1;
      data_addr <= a;
      data_wdata <= d;
      @(posedge mclk);
      data_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] x);
      @(posedge mclk);
      data_addr <= a;
      @(posedge mclk);
      #1;
      cmp(24'(data_rdata), 24'(x));
   endtask
   task automatic push_chk(input logic [16:0] x, input logic [16:0] r);
      cmp(24'(pc), 24'(x));
      cmp(24'({sp_step_up, stack_wr, stack_addr}), 24'h030101);
      cmp(24'(stack_wdata), 24'({1'b0, r[7:0]}));
      @(posedge mclk);
      #1;
      cmp(24'({sp_step_up, stack_wr, stack_addr}), 24'h030102);
      cmp(24'(stack_wdata), 24'(r[16:8]));
   endtask
   task automatic t_reset2;
      @(posedge mclk);
      srst <= 1'b1;
      start_high_opt <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      #1;
      cmp(24'({bank_select_flag, pc}), 24'h00FE00);
      cmp({c_reg, operand_high_reg, accumulator_reg}, 24'h000000);
   endtask
   task automatic t_regs;
      cmp(24'({bank_select_flag, pc}), 24'h000000);
      rd(16'hFE00, 8'h00);
      rd(16'hFE01, 8'h00);
      wr(16'hFE00, 8'h5A);
      wr(16'hFE01, 8'hC3);
      wr(16'hFE02, 8'h0F);
      rd(16'hFE00, 8'h5A);
      rd(16'hFE01, 8'hC3);
      rd(16'hFE02, 8'h0F);
      rd(16'hFE05, 8'h00);
      cmp(24'({ind_reg_region, sfr_region}), 24'h000001);
      rd(16'h0040, 8'h00);
      cmp(24'({ind_reg_region, sfr_region}), 24'h000002);
      @(posedge mclk);
      ext_access <= 1'b1;
      ext_low_addr <= 16'hBEEF;
      @(posedge mclk);
      ext_access <= 1'b0;
      #1;
      cmp(ext_addr, 24'hC3BEEF);
      @(posedge mclk);
      muldiv_wr <= 1'b1;
      muldiv_result <= 24'h123456;
      @(posedge mclk);
      muldiv_wr <= 1'b0;
      #1;
      cmp({c_reg, operand_high_reg, accumulator_reg}, 24'h123456);
   endtask
   task automatic t_flow;
      issue(CPS_OP_JUMP, 3'h3, 17'h1FFFE, 12'h000, 1'b0);
      cmp(24'(pc), 24'h01FFFE);
      issue(CPS_OP_SEQ, 3'h3, 17'h00000, 12'h000, 1'b0);
      cmp(24'({bank_select_flag, pc}), 24'h000001);
      issue(CPS_OP_RJUMP, 3'h2, 17'h00000, 12'h800, 1'b0);
      cmp(24'(pc), 24'h01F803);
      issue(CPS_OP_BRANCH, 3'h3, 17'h00000, 12'h080, 1'b1);
      cmp(24'(pc), 24'h01F786);
      issue(CPS_OP_BRANCH, 3'h3, 17'h00000, 12'h07F, 1'b0);
      cmp(24'(pc), 24'h01F789);
      issue(CPS_OP_ACALL, 3'h1, 17'h00000, 12'h000, 1'b0);
      push_chk(17'h1F7E0, 17'h1F78A);
      issue(CPS_OP_RELATIVE_CALL, 3'h2, 17'h00000, 12'h7FF, 1'b0);
      push_chk(17'h1FFE1, 17'h1F7E2);
      issue(CPS_OP_CALL, 3'h3, 17'h00ABC, 12'h000, 1'b0);
      push_chk(17'h00ABC, 17'h1FFE4);
      @(posedge mclk);
      op <= CPS_OP_RET;
      stack_rdata <= 9'h1AB;
      @(posedge mclk);
      op <= CPS_OP_HOLD;
      stack_rdata <= 9'h1CD;
      @(posedge mclk);
      stack_rdata <= 9'h032;
      #1;
      cmp(24'({sp_step_down, bank_select_flag, pc}), 24'h07ABCD);
      issue(CPS_OP_SEQ, 3'h2, 17'h00000, 12'h000, 1'b0);
      cmp(24'({bank_select_flag, pc}), 24'h03ABCF);
      @(posedge mclk);
      table_lookup_read <= 1'b1;
      table_addr <= 17'h1FF05;
      @(posedge mclk);
      table_lookup_read <= 1'b0;
      #1;
      cmp(24'(rom_addr), 24'h03FF05);
      for (int g = 0; g < 10; g++) begin
         @(posedge mclk);
         irq_accept <= 1'b1;
         irq_group <= 4'(g);
         @(posedge mclk);
         irq_accept <= 1'b0;
         #1;
         cmp(24'({bank_select_flag, pc}), 24'(3 + 8 * g));
         @(posedge mclk);
      end
      issue(CPS_OP_JUMP, 3'h3, 17'h1FF10, 12'h000, 1'b0);
      @(posedge mclk);
      #1;
      cmp(24'({opt_area_hit, rom_addr}), 24'h05FF10);
   endtask
   task automatic end_sim;
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      forever #5 mclk = ~mclk;
   end
   // Whole run is about 100 cycles
   initial begin
      repeat (5000) @(posedge mclk);
      n_mismatch++;
      end_sim;
   end
   initial begin
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      #1;
      t_regs;
      t_flow;
      t_reset2;
      end_sim;
   end
endmodule // tb_top
